/* common/tcs_defs.svh */
// command, reply and target constants for the touch calibration sequencer
`ifndef TCS_DEFS_SVH
`define TCS_DEFS_SVH

`define TCS_CMD_CAL        8'hBD
`define TCS_CMD_CHK_TOGGLE 8'hA5
`define TCS_RPL_ACCEPT     8'hC4
`define TCS_RPL_REJECT     8'hC8
`define TCS_RPL_PASS       8'hCB
`define TCS_RPL_FAIL       8'hCC

`define TCS_CHK_RESET      1'h0
`define TCS_CHK_BIT        5
`define TCS_TOL            10'h07F

`define TCS_SCHEME_2       4'h2
`define TCS_SCHEME_5       4'h5
`define TCS_SCHEME_13      4'hD
`define TCS_MAX_PTS        13

`define TCS_COORD_LO       10'h07F
`define TCS_COORD_ML       10'h13F
`define TCS_COORD_MID      10'h1FF
`define TCS_COORD_MH       10'h26F
`define TCS_COORD_HI       10'h37F

`endif

/* common/tcs_pkg.sv */
// types for the touch calibration sequencer
package tcs_pkg;

  typedef enum logic [2:0] {
    TCS_IDLE    = 3'b000,
    TCS_GETSEL  = 3'b001,
    TCS_ECHO1   = 3'b010,
    TCS_ECHO2   = 3'b011,
    TCS_WAITT   = 3'b100,
    TCS_NVWR    = 3'b101,
    TCS_REPLY   = 3'b110,
    TCS_VERDICT = 3'b111
  } tcs_fsm_t;

  typedef struct packed {
    logic [9:0] x;
    logic [9:0] y;
  } tcs_point_t;

  typedef struct packed {
    logic       wr;
    logic [3:0] addr;
    tcs_point_t pt;
  } tcs_nv_t;

  typedef struct packed {
    tcs_fsm_t    fsm;
    logic [7:0]  sel;
    logic        chk_en;
    logic [7:0]  tx_data;
    logic        tx_valid;
    logic        rx_ready;
    logic [7:0]  reply;
    logic [12:0] done_map;
    tcs_nv_t     nv;
    logic        busy;
  } tcs_state_t;

endpackage : tcs_pkg

/* rtl/tcs_axis_window.sv */
// one-axis tolerance window around a theoretical target
`timescale 1ns/10ps
`include "tcs_defs.svh"
module tcs_axis_window #(
  parameter int         W   = 10,
  parameter logic [9:0] TOL = `TCS_TOL
) (
  input  wire logic [W-1:0] sample,
  input  wire logic [W-1:0] target,
  output logic              in_win
);
  logic [W-1:0] diff;

  always_comb
  begin
    if (sample >= target)
      diff = sample - target;
    else
      diff = target - sample;
    in_win = (diff <= W'(TOL));
  end
endmodule : tcs_axis_window

/* rtl/tcs_target_table.sv */
// theoretical raw target for each calibration point index
`timescale 1ns/10ps
`include "tcs_defs.svh"
module tcs_target_table (
  input  wire logic [3:0]        idx,
  output tcs_pkg::tcs_point_t    pt
);
  // one table serves all schemes: smaller schemes are prefixes
  always_comb
  begin
    case (idx)
      4'h1: pt = '{`TCS_COORD_LO,  `TCS_COORD_LO};
      4'h2: pt = '{`TCS_COORD_HI,  `TCS_COORD_HI};
      4'h3: pt = '{`TCS_COORD_LO,  `TCS_COORD_HI};
      4'h4: pt = '{`TCS_COORD_MID, `TCS_COORD_MID};
      4'h5: pt = '{`TCS_COORD_HI,  `TCS_COORD_LO};
      4'h6: pt = '{`TCS_COORD_HI,  `TCS_COORD_MID};
      4'h7: pt = '{`TCS_COORD_MID, `TCS_COORD_HI};
      4'h8: pt = '{`TCS_COORD_LO,  `TCS_COORD_MID};
      4'h9: pt = '{`TCS_COORD_MID, `TCS_COORD_LO};
      4'hA: pt = '{`TCS_COORD_MH,  `TCS_COORD_ML};
      4'hB: pt = '{`TCS_COORD_MH,  `TCS_COORD_MH};
      4'hC: pt = '{`TCS_COORD_ML,  `TCS_COORD_MH};
      4'hD: pt = '{`TCS_COORD_ML,  `TCS_COORD_ML};
      default: pt = '{10'h000, 10'h000};
    endcase
  end
endmodule : tcs_target_table

/* rtl/tcs_sequencer.sv */
// touch calibration sequencer: command parse, echo, check, store, verdict
// How it works
// - two, five or thirteen point schemes per session
// - captured points written to non-volatile storage
// - checking on: accept within plus/minus 127 counts
// - checking on: out-of-window point is refused
// - toggle command switches coordinate checking
// - two-point targets 127/127 and 895/895
// - five-point adds 127/895, 511/511, 895/127
// - thirteen-point adds eight further fixed targets
// - select byte: high nibble count, low index
// - echo both bytes, then wait for touch on a valid select byte
// - checking off: every touch gets reject-code reply
// - after last point, self-test pass or fail
// - checking state visible in parameter reply byte
`timescale 1ns/10ps
`include "tcs_defs.svh"
module tcs_sequencer (
  input  wire logic                clk,
  input  wire logic                rstn,
  input  wire logic [7:0]          rx_data,
  input  wire logic                rx_valid,
  output logic                     rx_ready,
  output logic [7:0]               tx_data,
  output logic                     tx_valid,
  input  wire logic                tx_ready,
  input  wire logic                touch_valid,
  input  wire tcs_pkg::tcs_point_t touch_pt,
  output tcs_pkg::tcs_nv_t         nv_req,
  input  wire logic                nv_done,
  output logic                     chk_en,
  output logic [7:0]               param_byte12,
  output logic                     cal_busy
);
  tcs_pkg::tcs_state_t s_r;
  tcs_pkg::tcs_state_t s_nxt;
  tcs_pkg::tcs_point_t target;
  logic                in_x;
  logic                in_y;
  logic [3:0]          n_pts;
  logic [3:0]          idx;
  logic                sel_ok;
  logic [12:0]         need_map;
  logic [7:0]          param_nxt;
  logic [7:0]          param_r;

  assign n_pts = s_r.sel[7:4];
  assign idx   = s_r.sel[3:0];

  tcs_target_table u_table (
    .idx (idx),
    .pt  (target)
  );

  tcs_axis_window #(
    .W   (10),
    .TOL (`TCS_TOL)
  ) u_win_x (
    .sample (touch_pt.x),
    .target (target.x),
    .in_win (in_x)
  );

  tcs_axis_window #(
    .W   (10),
    .TOL (`TCS_TOL)
  ) u_win_y (
    .sample (touch_pt.y),
    .target (target.y),
    .in_win (in_y)
  );

  // only the three documented schemes with an in-range index proceed
  always_comb
  begin
    sel_ok = ((n_pts == `TCS_SCHEME_2) || (n_pts == `TCS_SCHEME_5) ||
              (n_pts == `TCS_SCHEME_13)) &&
             (idx != 4'h0) && (idx <= n_pts);
    need_map = 13'h0000;
    for (int i = 0; i < `TCS_MAX_PTS; i++)
    begin
      if (i < int'(n_pts))
        need_map[i] = 1'b1;
    end
  end

  always_comb
  begin
    s_nxt       = s_r;
    s_nxt.nv.wr = 1'b0;
    case (s_r.fsm)
      tcs_pkg::TCS_IDLE:
      begin
        if (rx_valid && s_r.rx_ready)
        begin
          if (rx_data == `TCS_CMD_CAL)
            s_nxt.fsm = tcs_pkg::TCS_GETSEL;
          else if (rx_data == `TCS_CMD_CHK_TOGGLE)
            s_nxt.chk_en = ~s_r.chk_en;
        end
      end
      tcs_pkg::TCS_GETSEL:
      begin
        if (rx_valid && s_r.rx_ready)
        begin
          s_nxt.sel      = rx_data;
          s_nxt.tx_data  = `TCS_CMD_CAL;
          s_nxt.tx_valid = 1'b1;
          s_nxt.rx_ready = 1'b0;
          s_nxt.busy     = 1'b1;
          s_nxt.fsm      = tcs_pkg::TCS_ECHO1;
          // a new session starts over with an empty capture map
          if (rx_data[3:0] == 4'h1 || rx_data[7:4] != s_r.sel[7:4])
            s_nxt.done_map = 13'h0000;
        end
      end
      tcs_pkg::TCS_ECHO1:
      begin
        if (tx_ready)
        begin
          s_nxt.tx_data = s_r.sel;
          s_nxt.fsm     = tcs_pkg::TCS_ECHO2;
        end
      end
      tcs_pkg::TCS_ECHO2:
      begin
        if (tx_ready)
        begin
          s_nxt.tx_valid = 1'b0;
          if (sel_ok)
            s_nxt.fsm = tcs_pkg::TCS_WAITT;
          else
          begin
            s_nxt.fsm      = tcs_pkg::TCS_IDLE;
            s_nxt.rx_ready = 1'b1;
            s_nxt.busy     = 1'b0;
          end
        end
      end
      tcs_pkg::TCS_WAITT:
      begin
        if (touch_valid)
        begin
          if (!s_r.chk_en)
          begin
            s_nxt.reply = `TCS_RPL_REJECT;
            s_nxt.nv.wr = 1'b1;
          end
          else if (in_x && in_y)
          begin
            s_nxt.reply = `TCS_RPL_ACCEPT;
            s_nxt.nv.wr = 1'b1;
          end
          else
            s_nxt.reply = `TCS_RPL_REJECT;
          s_nxt.nv.addr = idx - 4'h1;
          s_nxt.nv.pt   = touch_pt;
          if (s_nxt.nv.wr)
            s_nxt.fsm = tcs_pkg::TCS_NVWR;
          else
          begin
            s_nxt.tx_data  = s_nxt.reply;
            s_nxt.tx_valid = 1'b1;
            s_nxt.fsm      = tcs_pkg::TCS_REPLY;
          end
        end
      end
      tcs_pkg::TCS_NVWR:
      begin
        // reply waits for the storage to confirm the write
        if (nv_done)
        begin
          s_nxt.done_map[s_r.nv.addr] = 1'b1;
          s_nxt.tx_data  = s_r.reply;
          s_nxt.tx_valid = 1'b1;
          s_nxt.fsm      = tcs_pkg::TCS_REPLY;
        end
      end
      tcs_pkg::TCS_REPLY:
      begin
        if (tx_ready)
        begin
          if (idx == n_pts)
          begin
            // self-test: every point of the scheme has been stored
            if ((s_r.done_map & need_map) == need_map)
              s_nxt.tx_data = `TCS_RPL_PASS;
            else
              s_nxt.tx_data = `TCS_RPL_FAIL;
            s_nxt.fsm = tcs_pkg::TCS_VERDICT;
          end
          else
          begin
            s_nxt.tx_valid = 1'b0;
            s_nxt.rx_ready = 1'b1;
            s_nxt.busy     = 1'b0;
            s_nxt.fsm      = tcs_pkg::TCS_IDLE;
          end
        end
      end
      tcs_pkg::TCS_VERDICT:
      begin
        if (tx_ready)
        begin
          s_nxt.tx_valid = 1'b0;
          s_nxt.rx_ready = 1'b1;
          s_nxt.busy     = 1'b0;
          s_nxt.fsm      = tcs_pkg::TCS_IDLE;
        end
      end
      default:
      begin
        s_nxt.fsm      = tcs_pkg::TCS_IDLE;
        s_nxt.tx_valid = 1'b0;
        s_nxt.rx_ready = 1'b1;
        s_nxt.busy     = 1'b0;
      end
    endcase
    param_nxt                = 8'h00;
    param_nxt[`TCS_CHK_BIT]  = s_nxt.chk_en;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_r          <= '0;
      s_r.fsm      <= tcs_pkg::TCS_IDLE;
      s_r.chk_en   <= `TCS_CHK_RESET;
      s_r.rx_ready <= 1'b1;
      param_r      <= 8'h00;
    end
    else
    begin
      s_r     <= s_nxt;
      param_r <= param_nxt;
    end
  end

  assign rx_ready     = s_r.rx_ready;
  assign tx_data      = s_r.tx_data;
  assign tx_valid     = s_r.tx_valid;
  assign nv_req       = s_r.nv;
  assign chk_en       = s_r.chk_en;
  assign param_byte12 = param_r;
  assign cal_busy     = s_r.busy;
endmodule : tcs_sequencer

/* sim/tcs_host_model.sv */
// host-side reply sink and storage stand-in for the sequencer
`timescale 1ns/10ps
module tcs_host_model (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             slow,
  input  wire tcs_pkg::tcs_nv_t nv_req,
  output logic                  tx_ready,
  output logic                  nv_done
);
  logic [1:0] lat_r;
  // slow mode drops reply ready every other cycle and delays the store
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      tx_ready <= 1'b0;
      nv_done  <= 1'b0;
      lat_r    <= 2'h0;
    end
    else
    begin
      tx_ready <= slow ? !tx_ready : 1'b1;
      nv_done  <= lat_r == 2'h1;
      if (nv_req.wr)
        lat_r <= slow ? 2'h3 : 2'h1;
      else if (lat_r != 2'h0)
        lat_r <= lat_r - 2'h1;
    end
endmodule : tcs_host_model

/* sim/tcs_sequencer_sva.sv */
// port assertions for the touch calibration sequencer
`timescale 1ns/10ps
`include "tcs_defs.svh"
module tcs_sequencer_sva (
  input wire logic             clk,
  input wire logic             rstn,
  input wire logic [7:0]       rx_data,
  input wire logic             rx_valid,
  input wire logic             rx_ready,
  input wire logic [7:0]       tx_data,
  input wire logic             tx_valid,
  input wire logic             tx_ready,
  input wire tcs_pkg::tcs_nv_t nv_req,
  input wire logic             chk_en,
  input wire logic [7:0]       param_byte12
);
  logic take;
  logic getsel_r;
  assign take = rx_valid && rx_ready;
  // any byte after a calibrate byte is the select byte
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      getsel_r <= 1'b0;
    else if (take)
      getsel_r <= !getsel_r && rx_data == `TCS_CMD_CAL;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_tx_hold: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("reply byte moved while stalled");
  a_param_bit: assert property (
    param_byte12 == {2'h0, chk_en, 5'h00})
    else $error("parameter byte differs from checking bit");
  a_chk_toggle: assert property (
    take && !getsel_r && rx_data == `TCS_CMD_CHK_TOGGLE
    |=> chk_en != $past(chk_en))
    else $error("toggle byte did not flip checking");
  a_echo_first: assert property (
    take && getsel_r |=> tx_valid && tx_data == `TCS_CMD_CAL)
    else $error("calibrate byte not echoed first");
  a_echo_second: assert property (
    take && getsel_r ##1 tx_valid && tx_ready
    |=> tx_valid && tx_data == $past(rx_data, 2))
    else $error("select byte not echoed second");
  a_wr_pulse: assert property (
    nv_req.wr |=> !nv_req.wr)
    else $error("store strobe longer than one cycle");
  a_off_reply: assert property (
    nv_req.wr && !chk_en
    |-> ##[1:12] tx_valid && tx_data == `TCS_RPL_REJECT)
    else $error("unchecked touch without its reply");
  a_on_reply: assert property (
    nv_req.wr && chk_en
    |-> ##[1:12] tx_valid && tx_data == `TCS_RPL_ACCEPT)
    else $error("stored checked touch without accept");
  c_pass: cover property (tx_valid && tx_ready && tx_data == `TCS_RPL_PASS);
  c_fail: cover property (tx_valid && tx_ready && tx_data == `TCS_RPL_FAIL);
  c_on: cover property (nv_req.wr && chk_en);
endmodule : tcs_sequencer_sva

bind tcs_sequencer tcs_sequencer_sva chk_u (
  .clk(clk), .rstn(rstn), .rx_data(rx_data), .rx_valid(rx_valid),
  .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .nv_req(nv_req), .chk_en(chk_en),
  .param_byte12(param_byte12)
);

/* sim/tb_touch_calibration_sequencer.sv */
// self-checking bench for the touch calibration sequencer
`timescale 1ns/10ps
`include "tcs_defs.svh"
module tb_touch_calibration_sequencer;
  logic                clk = 1'b0, rstn = 1'b0, rx_valid = 1'b0;
  logic                touch_valid = 1'b0, slow = 1'b0;
  logic [7:0]          rx_data = 8'h00;
  tcs_pkg::tcs_point_t touch_pt = '0;
  logic                rx_ready, tx_valid, tx_ready, nv_done;
  logic                chk_en, cal_busy;
  logic [7:0]          tx_data, param_byte12;
  tcs_pkg::tcs_nv_t    nv_req;
  int                  err_count = 0, samples_checked = 0, wcnt, nv_cnt = 0;
  logic [9:0] tx13 [13] = '{10'h07F, 10'h37F, 10'h07F, 10'h1FF, 10'h37F,
    10'h37F, 10'h1FF, 10'h07F, 10'h1FF, 10'h26F, 10'h26F, 10'h13F, 10'h13F};
  logic [9:0] ty13 [13] = '{10'h07F, 10'h37F, 10'h37F, 10'h1FF, 10'h07F,
    10'h1FF, 10'h37F, 10'h1FF, 10'h07F, 10'h13F, 10'h26F, 10'h26F, 10'h13F};
  always #20 clk = ~clk;
  always @(posedge clk)
    if (rstn && nv_req.wr)
      nv_cnt++;
  tcs_sequencer dut_u (.clk(clk), .rstn(rstn), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .touch_valid(touch_valid),
    .touch_pt(touch_pt), .nv_req(nv_req), .nv_done(nv_done),
    .chk_en(chk_en), .param_byte12(param_byte12), .cal_busy(cal_busy));
  tcs_host_model host_u (.clk(clk), .rstn(rstn), .slow(slow),
    .nv_req(nv_req), .tx_ready(tx_ready), .nv_done(nv_done));
  task automatic give_verdict;
    if (err_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  task automatic chk(input string what, input logic [9:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      $display("Error %s expected %h seen %h", what, exp, seen);
      err_count++;
    end
  endtask : chk
  // every wait is bounded here; a hang ends the run
  task automatic step;
    @(posedge clk);
    #1;
    wcnt++;
    if (wcnt > 300)
    begin
      err_count++;
      give_verdict();
    end
  endtask : step
  task automatic send(input logic [7:0] a, b, input logic two);
    rx_valid = 1'b1;
    rx_data = a;
    wcnt = 0;
    while (!rx_ready) step;
    step;
    if (two)
    begin
      rx_data = b;
      while (!rx_ready) step;
      step;
    end
    rx_valid = 1'b0;
  endtask : send
  task automatic get(input logic [7:0] exp);
    wcnt = 0;
    while (!(tx_valid && tx_ready)) step;
    chk("tx_data", 10'(tx_data), 10'(exp));
    step;
  endtask : get
  task automatic point(input logic [7:0] sel, rep, input logic [9:0] x, y);
    send(`TCS_CMD_CAL, sel, 1'b1);
    get(`TCS_CMD_CAL);
    chk("cal_busy", 10'(cal_busy), 10'h001);
    get(sel);
    touch_pt = '{x: x, y: y};
    touch_valid = 1'b1;
    step;
    touch_valid = 1'b0;
    touch_pt = ~touch_pt;
    get(rep);
  endtask : point
  task automatic sc_invalid;
    send(8'h5A, 8'h00, 1'b0);
    step;
    send(`TCS_CMD_CAL, 8'h31, 1'b1);
    get(`TCS_CMD_CAL);
    get(8'h31);
    step;
    chk("rx_ready", 10'(rx_ready), 10'h001);
    chk("tx_valid", 10'(tx_valid), 10'h000);
    chk("cal_busy", 10'(cal_busy), 10'h000);
  endtask : sc_invalid
  task automatic sc_off_two;
    point(8'h21, `TCS_RPL_REJECT, 10'h000, 10'h3FF);
    chk("nv_addr", 10'(nv_req.addr), 10'h000);
    point(8'h22, `TCS_RPL_REJECT, 10'h3FF, 10'h000);
    get(`TCS_RPL_PASS);
    chk("nv_count", 10'(nv_cnt), 10'h002);
  endtask : sc_off_two
  task automatic sc_toggle;
    logic was;
    was = chk_en;
    send(`TCS_CMD_CHK_TOGGLE, 8'h00, 1'b0);
    step;
    chk("chk_en", 10'(chk_en), 10'(!was));
    chk("param", 10'(param_byte12), {4'h0, !was, 5'h00});
  endtask : sc_toggle
  // window edges at 127 inside and 128 outside, each axis alone
  task automatic sc_on_five;
    point(8'h51, `TCS_RPL_REJECT, 10'h07F, 10'h0FF);
    point(8'h51, `TCS_RPL_ACCEPT, 10'h0FE, 10'h000);
    point(8'h52, `TCS_RPL_ACCEPT, 10'h300, 10'h3FE);
    point(8'h53, `TCS_RPL_REJECT, 10'h0FF, 10'h37F);
    point(8'h54, `TCS_RPL_ACCEPT, 10'h180, 10'h27E);
    point(8'h55, `TCS_RPL_ACCEPT, 10'h3FE, 10'h000);
    get(`TCS_RPL_FAIL);
    chk("nv_count", 10'(nv_cnt), 10'h006);
    chk("nv_addr", 10'(nv_req.addr), 10'h004);
    // host answers the fail verdict by running the whole scheme again
    for (int i = 0; i < 5; i++)
      point({4'h5, 4'(i + 1)}, `TCS_RPL_ACCEPT, tx13[i], ty13[i]);
    get(`TCS_RPL_PASS);
  endtask : sc_on_five
  task automatic sc_on_thirteen;
    slow = 1'b1;
    for (int i = 0; i < 13; i++)
      point({4'hD, 4'(i + 1)}, `TCS_RPL_ACCEPT, tx13[i], ty13[i]);
    get(`TCS_RPL_PASS);
    chk("nv_x", nv_req.pt.x, tx13[12]);
    chk("nv_y", nv_req.pt.y, ty13[12]);
    slow = 1'b0;
  endtask : sc_on_thirteen
  // mid-run reset must drop checking back to its default
  task automatic sc_reset;
    wcnt = 0;
    rstn = 1'b0;
    step;
    step;
    rstn = 1'b1;
    chk("chk_en", 10'(chk_en), 10'(`TCS_CHK_RESET));
    chk("param", 10'(param_byte12), 10'h000);
    chk("cal_busy", 10'(cal_busy), 10'h000);
  endtask : sc_reset
  initial
  begin
    repeat (10) @(posedge clk);
    #1;
    rstn = 1'b1;
    chk("chk_en", 10'(chk_en), 10'(`TCS_CHK_RESET));
    sc_invalid;
    sc_off_two;
    sc_toggle;
    sc_on_five;
    sc_on_thirteen;
    sc_reset;
    sc_toggle;
    give_verdict;
  end
endmodule : tb_touch_calibration_sequencer
